// ==== design/wmb_pkg.sv ====
// Purpose: shared constants of the weigh transmitter register bank
// Assumes: register addresses are the 16-bit protocol register offsets
// Notes: result codes other than those from the executor are local choices
`default_nettype none

package wmb_pkg;

  // ==========================================================
  // register offsets, input (read only) area
  localparam logic [15:0] WMB_ADR_GROSS_W1 = 16'h7531;
  localparam logic [15:0] WMB_ADR_GROSS_W2 = 16'h7532;
  localparam logic [15:0] WMB_ADR_NET_W1 = 16'h7533;
  localparam logic [15:0] WMB_ADR_NET_W2 = 16'h7534;
  localparam logic [15:0] WMB_ADR_WSTAT = 16'h7535;
  localparam logic [15:0] WMB_ADR_CSTAT = 16'h7536;
  localparam logic [15:0] WMB_ADR_OSTAT = 16'h7537;
  localparam logic [15:0] WMB_ADR_CELL_UV = 16'h759F;

  // ==========================================================
  // register offsets, holding (read/write) area
  localparam logic [15:0] WMB_ADR_CMD = 16'h9C41;
  localparam logic [15:0] WMB_ADR_ARG1_W1 = 16'h9C42;
  localparam logic [15:0] WMB_ADR_ARG1_W2 = 16'h9C43;
  localparam logic [15:0] WMB_ADR_ARG2_W1 = 16'h9C44;
  localparam logic [15:0] WMB_ADR_ARG2_W2 = 16'h9C45;

  // ==========================================================
  // weighing status word bit positions
  localparam int WMB_WS_CHAN_HI = 15;
  localparam int WMB_WS_CHAN_LO = 14;
  localparam int WMB_WS_DIN2 = 9;
  localparam int WMB_WS_DIN1 = 8;
  localparam int WMB_WS_ZERO = 7;
  localparam int WMB_WS_PTARE = 6;
  localparam int WMB_WS_TARE = 5;
  localparam int WMB_WS_OVER = 4;
  localparam int WMB_WS_UNDER = 3;
  localparam int WMB_WS_STABLE = 2;
  localparam int WMB_WS_SIGN = 1;

  // ==========================================================
  // command status and output status layout
  localparam int WMB_CS_CODE_LO = 8;
  localparam int WMB_CS_RES_LO = 4;
  localparam int WMB_CS_CNT_LO = 0;
  localparam int WMB_OS_DOUT1 = 1;
  localparam int WMB_OS_DOUT2 = 0;

  // ==========================================================
  // command codes
  localparam logic [7:0] WMB_CMD_NONE = 8'h00;
  localparam logic [7:0] WMB_CMD_ZERO = 8'h01;
  localparam logic [7:0] WMB_CMD_TARE = 8'h02;
  localparam logic [7:0] WMB_CMD_PTARE = 8'h03;
  localparam logic [7:0] WMB_CMD_SETP1 = 8'h0A;
  localparam logic [7:0] WMB_CMD_SETP2 = 8'h0B;
  localparam logic [7:0] WMB_CMD_OUTS = 8'h19;
  localparam logic [7:0] WMB_CMD_REBOOT = 8'h22;

  // ==========================================================
  // result codes and reset values
  localparam logic [3:0] WMB_RES_UNKNOWN = 4'hF;
  localparam logic [15:0] WMB_RST_WORD = 16'h0000;
  localparam logic [3:0] WMB_RST_CNT = 4'h0;

  // command tracker states
  typedef enum logic [0:0] {
    WMB_CT_IDLE = 1'b0,
    WMB_CT_BUSY = 1'b1
  } wmb_ct_state_t;

endpackage

`default_nettype wire

// ==== design/wmb_pair_latch.sv ====
// Purpose: keeps the low word of a 32-bit value when its high word is read
// Assumes: the master reads the high word first, then the low word
// Notes: gives a coherent pair even while the weight keeps moving
`timescale 1ns/1ps
`default_nettype none

module wmb_pair_latch
  import wmb_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_capture,
  input wire logic [31:0] i_value,
  output logic [15:0] o_low_word
);

  // ==========================================================
  // low word hold
  logic [15:0] low_q;
  logic [15:0] low_d;

  // capture on the high word read, hold otherwise
  always_comb begin
    low_d = low_q;
    if (i_capture) begin
      low_d = i_value[15:0];
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      low_q <= WMB_RST_WORD;
    end else begin
      low_q <= low_d;
    end
  end

  assign o_low_word = low_q;

endmodule

`default_nettype wire

// ==== design/wmb_cmd_track.sv ====
// Purpose: command status word and command busy tracking
// Assumes: the executor pulses i_done once per issued command
// Notes: an unknown code completes at once with the unknown result
`timescale 1ns/1ps
`default_nettype none

module wmb_cmd_track
  import wmb_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_issue,
  input wire logic i_reject,
  input wire logic [7:0] i_code,
  input wire logic i_done,
  input wire logic [3:0] i_result,
  output logic [15:0] o_status,
  output logic o_busy
);

  // ==========================================================
  // tracker state
  wmb_ct_state_t state_q, state_d;
  logic [7:0] code_q, code_d;
  logic [3:0] res_q, res_d;
  logic [3:0] cnt_q, cnt_d;

  // next values; issue and reject never come while busy
  always_comb begin
    state_d = state_q;
    code_d = code_q;
    res_d = res_q;
    cnt_d = cnt_q;
    unique case (state_q)
      WMB_CT_IDLE: begin
        if (i_issue) begin
          code_d = i_code;
          state_d = WMB_CT_BUSY;
        end else if (i_reject) begin
          code_d = i_code;
          res_d = WMB_RES_UNKNOWN;
          cnt_d = cnt_q + 4'h1;
        end
      end
      WMB_CT_BUSY: begin
        if (i_done) begin
          res_d = i_result;
          cnt_d = cnt_q + 4'h1;
          state_d = WMB_CT_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= WMB_CT_IDLE;
      code_q <= WMB_CMD_NONE;
      res_q <= 4'h0;
      cnt_q <= WMB_RST_CNT;
    end else begin
      state_q <= state_d;
      code_q <= code_d;
      res_q <= res_d;
      cnt_q <= cnt_d;
    end
  end

  assign o_status = {code_q, res_q, cnt_q};
  assign o_busy = (state_q == WMB_CT_BUSY);

endmodule

`default_nettype wire

// ==== design/wmb_regs.sv ====
// Purpose: register bank of a single-scale weight transmitter
// Assumes: reads and writes arrive as one-cycle strobes with a register offset
// Notes: framing and the physical link sit outside; answers come one cycle later
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - active channel number sits in status word bits 15 and 14
// - digital input 1 live in bit 8, input 2 in bit 9
// - bit 7 set while gross weight is inside the zero zone
// - preset tare flag bit 6 high while a preset tare is active
// - tare flag bit 5 high while any tare is active
// - bit 4 high during overload, low otherwise
// - bit 3 high during underload, low otherwise
// - bit 2 high when weight is stable, low when unstable
// - bit 1 gives gross weight sign, 1 meaning negative
// - last command outcome code in command status bits 7 to 4
// - four-bit processed command count in command status bits 3 to 0
// - digital output 1 state in output status bit 1
// - digital output 2 state in output status bit 0
module wmb_regs
  import wmb_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst_n,
  // register access port
  input wire logic [15:0] i_reg_addr,
  input wire logic i_reg_rd,
  input wire logic i_reg_wr,
  input wire logic [15:0] i_reg_wdata,
  output logic [15:0] o_reg_rdata,
  output logic o_reg_ack,
  output logic o_reg_err,
  // weighing pipeline state
  input wire logic [31:0] i_gross_weight,
  input wire logic [31:0] i_net_weight,
  input wire logic [1:0] i_active_channel,
  input wire logic [1:0] i_digital_in,
  input wire logic i_zero_zone,
  input wire logic i_preset_tare_flag,
  input wire logic i_tare_active,
  input wire logic i_overload,
  input wire logic i_underload,
  input wire logic i_stable,
  input wire logic [15:0] i_cell_microvolt,
  input wire logic [1:0] i_digital_out,
  // command executor
  output logic o_cmd_start,
  output logic [7:0] o_cmd_code,
  output logic [31:0] o_cmd_arg1,
  output logic [31:0] o_cmd_arg2,
  input wire logic i_cmd_done,
  input wire logic [3:0] i_cmd_result
);

  // ==========================================================
  // declarations
  logic [15:0] rdata_q, rdata_d;
  logic ack_q, ack_d;
  logic err_q, err_d;
  logic start_q, start_d;
  logic [15:0] cmd_q, cmd_d;
  logic [15:0] a1w1_q, a1w1_d;
  logic [15:0] a1w2_q, a1w2_d;
  logic [15:0] a2w1_q, a2w1_d;
  logic [15:0] a2w2_q, a2w2_d;
  logic [15:0] weigh_status;
  logic [15:0] out_status;
  logic [15:0] cmd_status;
  logic [15:0] gross_low;
  logic [15:0] net_low;
  logic cmd_busy;
  logic cap_gross;
  logic cap_net;
  logic hit_ro;
  logic hit_rw;
  logic cmd_write;
  logic code_known;
  logic code_none;
  logic cmd_issue;
  logic cmd_reject;
  logic cmd_refuse;

  // ==========================================================
  // live status words

  // weighing status word; unused bits read as zero
  always_comb begin
    weigh_status = WMB_RST_WORD;
    weigh_status[WMB_WS_CHAN_HI:WMB_WS_CHAN_LO] = i_active_channel;
    weigh_status[WMB_WS_DIN1] = i_digital_in[0];
    weigh_status[WMB_WS_DIN2] = i_digital_in[1];
    weigh_status[WMB_WS_ZERO] = i_zero_zone;
    weigh_status[WMB_WS_PTARE] = i_preset_tare_flag;
    weigh_status[WMB_WS_TARE] = i_tare_active;
    weigh_status[WMB_WS_OVER] = i_overload;
    weigh_status[WMB_WS_UNDER] = i_underload;
    weigh_status[WMB_WS_STABLE] = i_stable;
    weigh_status[WMB_WS_SIGN] = i_gross_weight[31];
  end

  // output status word
  always_comb begin
    out_status = WMB_RST_WORD;
    out_status[WMB_OS_DOUT1] = i_digital_out[0];
    out_status[WMB_OS_DOUT2] = i_digital_out[1];
  end

  // ==========================================================
  // coherent weight pairs

  // the high word read freezes the low word, so a pair never tears
  assign cap_gross = i_reg_rd && (i_reg_addr == WMB_ADR_GROSS_W1);
  assign cap_net = i_reg_rd && (i_reg_addr == WMB_ADR_NET_W1);

  wmb_pair_latch u_gross_pair (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_capture(cap_gross),
    .i_value(i_gross_weight),
    .o_low_word(gross_low)
  );

  wmb_pair_latch u_net_pair (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_capture(cap_net),
    .i_value(i_net_weight),
    .o_low_word(net_low)
  );

  // ==========================================================
  // address decode
  always_comb begin
    hit_ro = 1'b0;
    hit_rw = 1'b0;
    unique case (i_reg_addr)
      WMB_ADR_GROSS_W1, WMB_ADR_GROSS_W2, WMB_ADR_NET_W1, WMB_ADR_NET_W2,
      WMB_ADR_WSTAT, WMB_ADR_CSTAT, WMB_ADR_OSTAT, WMB_ADR_CELL_UV: begin
        hit_ro = 1'b1;
      end
      WMB_ADR_CMD, WMB_ADR_ARG1_W1, WMB_ADR_ARG1_W2, WMB_ADR_ARG2_W1,
      WMB_ADR_ARG2_W2: begin
        hit_rw = 1'b1;
      end
      default: begin
        hit_ro = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // command decode
  // known codes
  always_comb begin
    unique case (i_reg_wdata[7:0])
      WMB_CMD_ZERO, WMB_CMD_TARE, WMB_CMD_PTARE, WMB_CMD_SETP1,
      WMB_CMD_SETP2, WMB_CMD_OUTS, WMB_CMD_REBOOT: begin
        code_known = (i_reg_wdata[15:8] == 8'h00);
      end
      default: begin
        code_known = 1'b0;
      end
    endcase
  end

  // a new command while one runs is refused, so the command code stays steady; argument writes still land
  assign cmd_write = i_reg_wr && (i_reg_addr == WMB_ADR_CMD);
  assign cmd_refuse = cmd_write && cmd_busy;
  assign code_none = (i_reg_wdata == {8'h00, WMB_CMD_NONE});
  assign cmd_issue = cmd_write && !cmd_busy && code_known;
  assign cmd_reject = cmd_write && !cmd_busy && !code_known && !code_none;

  wmb_cmd_track u_cmd_track (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_issue(cmd_issue),
    .i_reject(cmd_reject),
    .i_code(i_reg_wdata[7:0]),
    .i_done(i_cmd_done),
    .i_result(i_cmd_result),
    .o_status(cmd_status),
    .o_busy(cmd_busy)
  );

  // ==========================================================
  // holding registers
  always_comb begin
    cmd_d = cmd_q;
    a1w1_d = a1w1_q;
    a1w2_d = a1w2_q;
    a2w1_d = a2w1_q;
    a2w2_d = a2w2_q;
    start_d = cmd_issue;
    if (i_reg_wr && !cmd_refuse) begin
      unique case (i_reg_addr)
        WMB_ADR_CMD: cmd_d = i_reg_wdata;
        WMB_ADR_ARG1_W1: a1w1_d = i_reg_wdata;
        WMB_ADR_ARG1_W2: a1w2_d = i_reg_wdata;
        WMB_ADR_ARG2_W1: a2w1_d = i_reg_wdata;
        WMB_ADR_ARG2_W2: a2w2_d = i_reg_wdata;
        default: cmd_d = cmd_q;
      endcase
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cmd_q <= WMB_RST_WORD;
      a1w1_q <= WMB_RST_WORD;
      a1w2_q <= WMB_RST_WORD;
      a2w1_q <= WMB_RST_WORD;
      a2w2_q <= WMB_RST_WORD;
      start_q <= 1'b0;
    end else begin
      cmd_q <= cmd_d;
      a1w1_q <= a1w1_d;
      a1w2_q <= a1w2_d;
      a2w1_q <= a2w1_d;
      a2w2_q <= a2w2_d;
      start_q <= start_d;
    end
  end

  // ==========================================================
  // read and write answer
  always_comb begin
    rdata_d = WMB_RST_WORD;
    ack_d = i_reg_rd || i_reg_wr;
    err_d = 1'b0;
    if (i_reg_rd) begin
      unique case (i_reg_addr)
        WMB_ADR_GROSS_W1: rdata_d = i_gross_weight[31:16];
        WMB_ADR_GROSS_W2: rdata_d = gross_low;
        WMB_ADR_NET_W1: rdata_d = i_net_weight[31:16];
        WMB_ADR_NET_W2: rdata_d = net_low;
        WMB_ADR_WSTAT: rdata_d = weigh_status;
        WMB_ADR_CSTAT: rdata_d = cmd_status;
        WMB_ADR_OSTAT: rdata_d = out_status;
        WMB_ADR_CELL_UV: rdata_d = i_cell_microvolt;
        WMB_ADR_CMD: rdata_d = cmd_q;
        WMB_ADR_ARG1_W1: rdata_d = a1w1_q;
        WMB_ADR_ARG1_W2: rdata_d = a1w2_q;
        WMB_ADR_ARG2_W1: rdata_d = a2w1_q;
        WMB_ADR_ARG2_W2: rdata_d = a2w2_q;
        default: err_d = 1'b1;
      endcase
    end else if (i_reg_wr) begin
      // input registers and unmapped offsets refuse writes
      err_d = !hit_rw || hit_ro || cmd_refuse;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_q <= WMB_RST_WORD;
      ack_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      ack_q <= ack_d;
      err_q <= err_d;
    end
  end

  // ==========================================================
  // outputs
  assign o_reg_rdata = rdata_q;
  assign o_reg_ack = ack_q;
  assign o_reg_err = err_q;
  // preset tare value travels in argument 1
  assign o_cmd_start = start_q;
  assign o_cmd_code = cmd_q[7:0];
  assign o_cmd_arg1 = {a1w1_q, a1w2_q};
  assign o_cmd_arg2 = {a2w1_q, a2w2_q};

endmodule

`default_nettype wire

// ==== tb/wmb_regs_checker.sv ====
// Purpose: port assertions for the weigh register bank
// Assumes: strobes are one-cycle pulses, one command at a time
// Notes: command busy is rebuilt here from port traffic
`timescale 1ns/1ps
`default_nettype none

module wmb_regs_checker
  import wmb_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic [15:0] i_reg_addr,
  input wire logic i_reg_rd,
  input wire logic i_reg_wr,
  input wire logic [15:0] i_reg_wdata,
  input wire logic [15:0] o_reg_rdata,
  input wire logic o_reg_ack,
  input wire logic o_reg_err,
  input wire logic [31:0] i_gross_weight,
  input wire logic [1:0] i_active_channel,
  input wire logic [1:0] i_digital_in,
  input wire logic i_zero_zone,
  input wire logic i_preset_tare_flag,
  input wire logic i_tare_active,
  input wire logic i_overload,
  input wire logic i_underload,
  input wire logic i_stable,
  input wire logic [1:0] i_digital_out,
  input wire logic o_cmd_start,
  input wire logic [7:0] o_cmd_code,
  input wire logic i_cmd_done
);
  // ==========================================================
  // expected words from the live inputs
  logic [15:0] ws_exp;
  logic [15:0] os_exp;
  logic [15:0] gross_hi;
  logic cmd_ok;
  logic busy_q;
  logic busy_d;
  assign ws_exp = {i_active_channel, 4'h0, i_digital_in, i_zero_zone, i_preset_tare_flag,
    i_tare_active, i_overload, i_underload, i_stable, i_gross_weight[31], 1'b0};
  assign os_exp = {14'h0000, i_digital_out[0], i_digital_out[1]};
  assign gross_hi = i_gross_weight[31:16];
  assign cmd_ok = i_reg_wr && (i_reg_addr == WMB_ADR_CMD) && !busy_q &&
    (i_reg_wdata inside {16'h0001, 16'h0002, 16'h0003, 16'h000A, 16'h000B, 16'h0019,
    16'h0022});

  // busy tracker; a write in the done cycle is refused, done ends it
  always_comb begin
    busy_d = busy_q;
    if (i_cmd_done) busy_d = 1'b0;
    if (cmd_ok) busy_d = 1'b1;
  end
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) busy_q <= 1'b0;
    else busy_q <= busy_d;
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  property p_ack;
    (i_reg_rd || i_reg_wr) |=> o_reg_ack;
  endproperty
  a_ack: assert property (p_ack) else $error("no answer after strobe");
  property p_ws_hi;
    (i_reg_rd && i_reg_addr == WMB_ADR_WSTAT) |=>
      (o_reg_rdata & 16'hFF00) == ($past(ws_exp) & 16'hFF00);
  endproperty
  a_ws_hi: assert property (p_ws_hi) else $error("status high byte wrong");
  property p_ws_lo;
    (i_reg_rd && i_reg_addr == WMB_ADR_WSTAT) ##1 1'b1 |->
      (o_reg_rdata & 16'h00FF) == ($past(ws_exp) & 16'h00FF);
  endproperty
  a_ws_lo: assert property (p_ws_lo) else $error("flags wrong");
  property p_os;
    (i_reg_rd && i_reg_addr == WMB_ADR_OSTAT) |=> o_reg_rdata == $past(os_exp);
  endproperty
  a_os: assert property (p_os) else $error("output status wrong");
  property p_gross;
    (i_reg_rd && i_reg_addr == WMB_ADR_GROSS_W1) |=> o_reg_rdata == $past(gross_hi);
  endproperty
  a_gross: assert property (p_gross) else $error("gross high word wrong");
  property p_start;
    cmd_ok |=> o_cmd_start && ({8'h00, o_cmd_code} == $past(i_reg_wdata));
  endproperty
  a_start: assert property (p_start) else $error("command not started");
  property p_pulse;
    o_cmd_start |=> !o_cmd_start;
  endproperty
  a_pulse: assert property (p_pulse) else $error("start longer than one cycle");
  property p_busy;
    (i_reg_wr && i_reg_addr == WMB_ADR_CMD && busy_q && !i_cmd_done) |=>
      o_reg_err && !o_cmd_start;
  endproperty
  a_busy: assert property (p_busy) else $error("command accepted while busy");
  property p_unmap;
    (i_reg_rd && i_reg_addr == 16'h0000) |=> o_reg_err && o_reg_rdata == 16'h0000;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not refused");
endmodule

bind wmb_regs wmb_regs_checker i_chk (.*);

`default_nettype wire

// ==== tb/wmb_master.sv ====
// Purpose: register master on the far side of the bank
// Assumes: one strobe per transfer, answer one cycle later
// Notes: a released address and write data show the inverse of the last value
`timescale 1ns/1ps
`default_nettype none

module wmb_master (
  input wire logic i_clock,
  input wire logic [15:0] i_rdata,
  input wire logic i_ack,
  input wire logic i_err,
  output logic [15:0] o_addr,
  output logic o_rd,
  output logic o_wr,
  output logic [15:0] o_wdata
);
  // ==========================================================
  // bus idle at time zero
  initial begin
    o_addr = 16'h0000;
    o_rd = 1'b0;
    o_wr = 1'b0;
    o_wdata = 16'hFFFF;
  end

  // one transfer; a falling edge passes first so a strobe never changes twice in one step
  task automatic xfer(input logic w, input logic [15:0] a, input logic [15:0] d,
      output logic [15:0] q, output logic [1:0] ae);
    @(negedge i_clock);
    o_addr = a;
    o_wdata = d;
    o_rd = !w;
    o_wr = w;
    @(negedge i_clock);
    q = i_rdata;
    ae = {i_ack, i_err};
    o_rd = 1'b0;
    o_wr = 1'b0;
    o_addr = ~a;
    o_wdata = ~d;
  endtask
endmodule

`default_nettype wire

// ==== tb/tb_weigh_modbus_register_map.sv ====
// Purpose: self-checking bench for the weigh register bank
// Assumes: executor and weighing inputs are driven here
// Notes: inputs change at the falling edge only
`timescale 1ns/1ps
`default_nettype none

module tb_weigh_modbus_register_map;
  import wmb_pkg::*;
  logic i_clock = 1'b0;
  logic i_rst_n, i_reg_rd, i_reg_wr, o_reg_ack, o_reg_err, o_cmd_start, i_cmd_done;
  logic [15:0] i_reg_addr, i_reg_wdata, o_reg_rdata, i_cell_microvolt;
  logic [31:0] i_gross_weight, i_net_weight, o_cmd_arg1, o_cmd_arg2;
  logic [1:0] i_active_channel, i_digital_in, i_digital_out;
  logic [7:0] o_cmd_code;
  logic [3:0] i_cmd_result;
  logic [5:0] fl;
  wire logic i_zero_zone, i_preset_tare_flag, i_tare_active, i_overload, i_underload;
  wire logic i_stable;
  int n_errors = 0;
  int checked = 0;
  assign {i_zero_zone, i_preset_tare_flag, i_tare_active, i_overload, i_underload,
    i_stable} = fl;

  // ==========================================================
  // clock, design, far-side master
  always #5 i_clock = ~i_clock;
  wmb_regs i_dut (.*);
  wmb_master i_mst (.i_clock(i_clock), .i_rdata(o_reg_rdata), .i_ack(o_reg_ack),
    .i_err(o_reg_err), .o_addr(i_reg_addr), .o_rd(i_reg_rd), .o_wr(i_reg_wr),
    .o_wdata(i_reg_wdata));

  // ==========================================================
  // shared tasks
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d,
      input logic e, output logic [15:0] q);
    logic [1:0] ae;
    i_mst.xfer(w, a, d, q, ae);
    chk(ae, {1'b1, e});
  endtask
  task automatic end_sim();
    if (n_errors == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ==========================================================
  // scenarios
  // walking one over the flags, counting channel and inputs, with both signs
  task automatic t_status();
    logic [15:0] q;
    for (int i = 0; i < 8; i++) begin
      fl = 6'(1 << i);
      i_active_channel = 2'(i);
      i_digital_in = 2'(i + 1);
      i_gross_weight = i[0] ? 32'hFFFF_FFF0 : 32'h0000_0010;
      acc(1'b0, WMB_ADR_WSTAT, 16'h0000, 1'b0, q);
      chk(q[15:8], {i_active_channel, 4'h0, i_digital_in});
      chk(q[7:0], {fl, i_gross_weight[31], 1'b0});
    end
  endtask
  task automatic t_outs();
    logic [15:0] q;
    for (int i = 0; i < 4; i++) begin
      i_digital_out = 2'(i);
      acc(1'b0, WMB_ADR_OSTAT, 16'h0000, 1'b0, q);
      chk(q, {14'h0000, i_digital_out[0], i_digital_out[1]});
    end
  endtask
  // low word stays coherent with the high word read just before
  task automatic t_weights();
    logic [15:0] q;
    i_gross_weight = 32'h1234_5678;
    i_net_weight = 32'h9ABC_DEF0;
    acc(1'b0, WMB_ADR_GROSS_W2, 16'h0000, 1'b0, q);
    chk(q, 16'h0000);
    acc(1'b0, WMB_ADR_GROSS_W1, 16'h0000, 1'b0, q);
    chk(q, 16'h1234);
    i_gross_weight = 32'h0000_0001;
    acc(1'b0, WMB_ADR_GROSS_W2, 16'h0000, 1'b0, q);
    chk(q, 16'h5678);
    acc(1'b0, WMB_ADR_NET_W1, 16'h0000, 1'b0, q);
    chk(q, 16'h9ABC);
    acc(1'b0, WMB_ADR_NET_W2, 16'h0000, 1'b0, q);
    chk(q, 16'hDEF0);
    acc(1'b0, WMB_ADR_CELL_UV, 16'h0000, 1'b0, q);
    chk(q, i_cell_microvolt);
    acc(1'b1, WMB_ADR_GROSS_W1, 16'h5555, 1'b1, q);
    acc(1'b0, 16'h0000, 16'h0000, 1'b1, q);
    chk(q, 16'h0000);
  endtask
  // every code and one unknown code twice each, so the count wraps to zero
  task automatic t_cmd();
    logic [7:0] codes [8] = '{8'h01, 8'h02, 8'h03, 8'h0A, 8'h0B, 8'h19, 8'h22, 8'h55};
    logic [15:0] q;
    logic [7:0] c;
    logic [3:0] r;
    logic [3:0] n;
    n = 4'h0;
    acc(1'b1, WMB_ADR_ARG1_W1, 16'h0000, 1'b0, q);
    acc(1'b1, WMB_ADR_ARG1_W2, 16'h03E8, 1'b0, q);
    acc(1'b1, WMB_ADR_ARG2_W2, 16'h7FFE, 1'b0, q);
    acc(1'b1, WMB_ADR_ARG2_W1, 16'h8001, 1'b0, q);
    for (int i = 0; i < 16; i++) begin
      c = codes[i % 8];
      acc(1'b1, WMB_ADR_CMD, {8'h00, c}, 1'b0, q);
      chk(o_cmd_start, c != 8'h55);
      r = WMB_RES_UNKNOWN;
      if (c != 8'h55) begin
        chk(o_cmd_code, c);
        chk(o_cmd_arg1, 32'h0000_03E8);
        chk(o_cmd_arg2, 32'h8001_7FFE);
        acc(1'b0, WMB_ADR_CSTAT, 16'h0000, 1'b0, q);
        chk(q[15:8], c);
        acc(1'b1, WMB_ADR_CMD, 16'h0001, 1'b1, q);
        chk(o_cmd_code, c);
        r = 4'(i);
        i_cmd_result = r;
        i_cmd_done = 1'b1;
        @(negedge i_clock);
        i_cmd_done = 1'b0;
      end
      n = n + 4'h1;
      acc(1'b0, WMB_ADR_CSTAT, 16'h0000, 1'b0, q);
      chk(q, {c, r, n});
    end
    acc(1'b1, WMB_ADR_CMD, 16'h0000, 1'b0, q);
    chk(o_cmd_start, 1'b0);
    acc(1'b0, WMB_ADR_CSTAT, 16'h0000, 1'b0, q);
    chk(q[3:0], n);
    // unknown code with a nonzero high byte, then a stray done while idle
    acc(1'b1, WMB_ADR_CMD, 16'h0101, 1'b0, q);
    chk(o_cmd_start, 1'b0);
    acc(1'b0, WMB_ADR_CMD, 16'h0000, 1'b0, q);
    chk(q, 16'h0101);
    acc(1'b0, WMB_ADR_ARG2_W1, 16'h0000, 1'b0, q);
    chk(q, 16'h8001);
    i_cmd_result = 4'h5;
    i_cmd_done = 1'b1;
    @(negedge i_clock);
    i_cmd_done = 1'b0;
    acc(1'b0, WMB_ADR_CSTAT, 16'h0000, 1'b0, q);
    chk(q, {8'h01, WMB_RES_UNKNOWN, n + 4'h1});
  endtask

  // ==========================================================
  // main sequence, reset held two cycles
  initial begin
    i_rst_n = 1'b0;
    fl = 6'h00;
    i_gross_weight = 32'h0000_0000;
    i_net_weight = 32'h0000_0000;
    i_active_channel = 2'h0;
    i_digital_in = 2'h0;
    i_digital_out = 2'h0;
    i_cell_microvolt = 16'hA5C3;
    i_cmd_done = 1'b0;
    i_cmd_result = 4'h0;
    repeat (2) @(negedge i_clock);
    i_rst_n = 1'b1;
    @(negedge i_clock);
    // outputs stay quiet after reset until a strobe comes
    chk({o_reg_ack, o_reg_err, o_cmd_start, o_reg_rdata}, 19'h00000);
    t_status();
    t_outs();
    t_weights();
    t_cmd();
    end_sim();
  end

  // watchdog well beyond the few hundred cycles the scenarios need
  initial begin
    #200000;
    n_errors++;
    end_sim();
  end
endmodule

`default_nettype wire
